// [core/i2cs_bit_sync.sv]
// Two-stage synchroniser for a group of levels
`timescale 1ns/1ps
`default_nettype none

module i2cs_bit_sync #(
   parameter int unsigned      WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // Clock and reset of the receiving domain
   input  wire logic             clk_in,
   input  wire logic             arst_n_in,
   // Asynchronous levels in, synchronised levels out
   input  wire logic [WIDTH-1:0] d_in,
   output logic      [WIDTH-1:0] q_out
);

   logic [WIDTH-1:0] meta;

   // First stage feeds only the second stage
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         meta  <= RST_VAL;
         q_out <= RST_VAL;
      end else begin
         meta  <= d_in;
         q_out <= meta;
      end
   end

endmodule : i2cs_bit_sync

`default_nettype wire

// [core/i2cs_slave.sv]
// I2C slave engine: 10-bit address match, reception, transmission
//
// Functional notes
// - High address byte must read 11110, A9, A8, R/W; A9/A8 from address bits 2:1.
// - After acking a high write address, set update flag and hold SCL.
// - Low address byte compared in all eight bits with the address register.
// - After any low address byte set event and update flags; address write clears.
// - Session starts with full write match; reads need restart plus high read address.
// - Matched write address clears status R/W, fills buffer, is acknowledged.
// - Address NACKed while buffer full or overflow; overwrite enable relaxes this.
// - Event flag set per byte; software clears it; buffer read clears full flag.
// - With stretch enable, SCL held after each received byte until release bit.
// - Start sets start flag, optionally event; stop sets stop flag, goes idle.
// - Address hold: after eighth fall of matched address, event and clear release.
// - Data hold: after eighth fall of each data byte, event and clear release.
// - During a hold the ack level comes from the ack select bit.
// - Ack-time flag tells whether an event came before or after acknowledge.
// - In hold modes event still set at ninth fall after ACK; after NACK only for the low address byte.
// - Hold modes with stretch enable also stretch after the acknowledge bit.
// - Matched read address sets status R/W, fills buffer, ACKs ninth bit.
// - After acking a read request clear release bit and hold SCL.
// - Writing transmit data loads the shifter; bits change on falling SCL.
// - Master ack latched at ninth rising edge; after ACK stretch for next byte.
// - Master NACK: no stretch, event still set, slave goes unaddressed.
// - Transmit event raised on the ninth falling SCL edge of each byte.
// - Collision while sending with detection on: flag it and go idle.
// - With both holds off the acknowledge is generated by hardware.
// - Ack-time flag set after eighth fall when addressed, only with a hold on.
`timescale 1ns/1ps
`default_nettype none

module i2cs_slave
   import i2cs_pkg::*;
(
   // System clock, link sampling clock, reset
   input  wire logic       clk_in,
   input  wire logic       link_clk_in,
   input  wire logic       arst_n_in,
   // Bus pins, open drain
   input  wire logic       scl_in,
   output logic            scl_out,
   output logic            scl_oe_n_out,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_n_out,
   // Configuration levels
   input  wire logic       stretch_enable_in,
   input  wire logic       address_hold_enable_in,
   input  wire logic       data_hold_enable_in,
   input  wire logic       ack_value_select_in,
   input  wire logic       buffer_overwrite_enable_in,
   input  wire logic       slave_collision_detect_enable_in,
   input  wire logic       start_event_enable_in,
   // Software strobes
   input  wire logic [7:0] sw_wdata_in,
   input  wire logic       buffer_write_in,
   input  wire logic       buffer_read_in,
   input  wire logic       address_write_in,
   input  wire logic       clock_release_set_in,
   input  wire logic       event_clear_in,
   input  wire logic       overflow_clear_in,
   input  wire logic       collision_clear_in,
   // Status
   output logic            serial_event_flag_out,
   output logic            buffer_full_flag_out,
   output logic            receive_overflow_flag_out,
   output logic            address_update_flag_out,
   output logic            ack_time_flag_out,
   output logic            ack_received_flag_out,
   output logic            read_write_flag_out,
   output logic            start_seen_out,
   output logic            stop_seen_out,
   output logic            bus_collision_flag_out,
   output logic            clock_release_bit_out,
   output logic [7:0]      serial_data_buffer_out,
   output logic [7:0]      slave_address_reg_out
);

   i2cs_link_t l;
   i2cs_link_t nl;
   i2cs_sys_t  s;
   i2cs_sys_t  ns;
   i2cs_cfg_t  cfg_l;
   logic       scl_s;
   logic       sda_s;
   logic       rel_pulse;
   logic       ev_pulse;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_det;
   logic       stop_det;

   // Bus pins enter the link domain through two flip-flops
   i2cs_bit_sync #(
      .WIDTH   (2),
      .RST_VAL (2'h3)
   ) u_pin_sync (
      .clk_in    (link_clk_in),
      .arst_n_in (arst_n_in),
      .d_in      ({scl_in, sda_in}),
      .q_out     ({scl_s, sda_s})
   );

   // Configuration is registered on the system side, then synchronised
   i2cs_bit_sync #(
      .WIDTH   ($bits(i2cs_cfg_t)),
      .RST_VAL ('0)
   ) u_cfg_sync (
      .clk_in    (link_clk_in),
      .arst_n_in (arst_n_in),
      .d_in      (s.cfg),
      .q_out     (cfg_l)
   );

   // Release requests travel to the link side as a toggle
   i2cs_toggle_sync u_rel_sync (
      .clk_in    (link_clk_in),
      .arst_n_in (arst_n_in),
      .toggle_in (s.rel_tog),
      .pulse_out (rel_pulse)
   );

   // Link events travel back as a toggle; the event word stays stable
   i2cs_toggle_sync u_ev_sync (
      .clk_in    (clk_in),
      .arst_n_in (arst_n_in),
      .toggle_in (l.ev_tog),
      .pulse_out (ev_pulse)
   );

   // Bus edges and conditions seen on the synchronised pins
   assign scl_rise  = scl_s & ~l.scl_q;
   assign scl_fall  = ~scl_s & l.scl_q;
   assign start_det = scl_s & l.scl_q & l.sda_q & ~sda_s;
   assign stop_det  = scl_s & l.scl_q & ~l.sda_q & sda_s;

   // Link engine; the address and transmit words are read only while
   // software keeps them still (stretch held or bus between bytes)
   always_comb begin
      logic     hi_ok;
      logic     match;
      logic     hold;
      i2cs_ev_t ev;
      hi_ok = 1'b0;
      match = 1'b0;
      hold  = 1'b0;
      ev    = '0;
      nl    = l;
      nl.scl_q = scl_s;
      nl.sda_q = sda_s;
      if (start_det) begin
         // Start or restart resets the slave to take an address
         ev.start    = 1'b1;
         nl.state    = L_RX;
         nl.kind     = K_HI;
         nl.bitcnt   = 4'h0;
         nl.rd       = 1'b0;
         nl.scl_oe_n = 1'b1;
         nl.sda_oe_n = 1'b1;
      end else if (stop_det) begin
         ev.stop        = 1'b1;
         nl.state       = L_IDLE;
         nl.prior_match = 1'b0;
         nl.scl_oe_n    = 1'b1;
         nl.sda_oe_n    = 1'b1;
      end else begin
         unique case (l.state)
            L_IDLE: begin
               nl.state = L_IDLE;
            end
            L_RX: begin
               if (scl_rise) begin
                  nl.shreg  = {l.shreg[6:0], sda_s};
                  nl.bitcnt = l.bitcnt + 4'h1;
               end
               if (scl_fall && l.bitcnt == I2CS_BYTE_BITS) begin
                  nl.bitcnt = 4'h0;
                  hi_ok = (l.shreg[7:3] == I2CS_HI_PATTERN) &&
                     (l.shreg[2:1] == s.addr[I2CS_A9_POS:I2CS_A8_POS]);
                  unique case (l.kind)
                     K_HI:    match = hi_ok && (!l.shreg[I2CS_RW_POS] ||
                                               l.prior_match);
                     K_LO:    match = (l.shreg == s.addr);
                     default: match = 1'b1;
                  endcase
                  // A failed high match or a new write address drops the
                  // earlier full match, so a read needs a fresh session
                  if (l.kind == K_HI) begin
                     nl.rd = l.shreg[I2CS_RW_POS];
                     if (!hi_ok || !l.shreg[I2CS_RW_POS]) begin
                        nl.prior_match = 1'b0;
                     end
                  end
                  hold = (l.kind == K_DATA) ? cfg_l.data_hold
                                            : cfg_l.addr_hold;
                  if (!match && l.kind != K_LO) begin
                     nl.state = L_IDLE;
                  end else begin
                     ev.load = match;
                     ev.rw   = nl.rd;
                     ev.data = l.shreg;
                     if (match && hold) begin
                        // Stretch before the acknowledge
                        ev.hold     = 1'b1;
                        nl.scl_oe_n = 1'b0;
                        nl.after    = A_ACK;
                        nl.state    = L_WAIT;
                     end else begin
                        nl.ack_ok   = match && !cfg_l.ovf_block;
                        nl.sda_oe_n = !(match && !cfg_l.ovf_block);
                        nl.state    = L_ACK;
                     end
                  end
               end
            end
            L_ACK: begin
               if (scl_fall) begin
                  nl.sda_oe_n = 1'b1;
                  if (l.kind == K_LO) begin
                     // Matched or not, software must rewrite the address
                     ev.done        = 1'b1;
                     ev.ua          = 1'b1;
                     nl.scl_oe_n    = 1'b0;
                     nl.state       = L_WAIT;
                     nl.after       = l.ack_ok ? A_RX : A_IDLE;
                     nl.kind        = K_DATA;
                     nl.prior_match = l.ack_ok;
                  end else if (!l.ack_ok) begin
                     nl.state = L_IDLE;
                  end else begin
                     ev.done     = 1'b1;
                     nl.scl_oe_n = 1'b0;
                     nl.state    = L_WAIT;
                     if (l.kind == K_HI && l.rd) begin
                        ev.cut   = 1'b1;
                        nl.after = A_TX;
                     end else if (l.kind == K_HI) begin
                        ev.ua    = 1'b1;
                        nl.after = A_RX;
                        nl.kind  = K_LO;
                     end else if (cfg_l.stretch) begin
                        ev.cut   = 1'b1;
                        nl.after = A_RX;
                     end else begin
                        nl.scl_oe_n = 1'b1;
                        nl.state    = L_RX;
                     end
                  end
               end
            end
            L_WAIT: begin
               // SCL is held low here until software lets it go
               if (rel_pulse) begin
                  nl.scl_oe_n = 1'b1;
                  nl.bitcnt   = 4'h0;
                  unique case (l.after)
                     A_ACK: begin
                        nl.ack_ok   = !cfg_l.ack_val;
                        nl.sda_oe_n = cfg_l.ack_val;
                        nl.state    = L_ACK;
                     end
                     A_RX: begin
                        nl.state = L_RX;
                     end
                     A_TX: begin
                        // First bit is on SDA before SCL may rise
                        nl.shreg    = s.tx;
                        nl.sda_oe_n = s.tx[7];
                        nl.state    = L_TX;
                     end
                     A_IDLE: begin
                        nl.state = L_IDLE;
                     end
                  endcase
               end
            end
            L_TX: begin
               if (scl_rise && l.sda_oe_n && !sda_s && cfg_l.coll_en) begin
                  ev.coll     = 1'b1;
                  nl.sda_oe_n = 1'b1;
                  nl.state    = L_IDLE;
               end else if (scl_fall) begin
                  nl.bitcnt = l.bitcnt + 4'h1;
                  if (l.bitcnt == I2CS_TX_LAST) begin
                     nl.sda_oe_n = 1'b1;
                     nl.state    = L_TXACK;
                  end else begin
                     nl.shreg    = {l.shreg[6:0], 1'b0};
                     nl.sda_oe_n = l.shreg[6];
                  end
               end
            end
            L_TXACK: begin
               if (scl_rise) begin
                  ev.ackrx   = 1'b1;
                  ev.ack_bit = sda_s;
                  nl.ack_ok  = !sda_s;
               end
               if (scl_fall) begin
                  ev.done = 1'b1;
                  if (l.ack_ok) begin
                     ev.cut      = 1'b1;
                     nl.scl_oe_n = 1'b0;
                     nl.after    = A_TX;
                     nl.state    = L_WAIT;
                  end else begin
                     nl.state = L_IDLE;
                  end
               end
            end
         endcase
      end
      // One event word per toggle; events are many link cycles apart
      if (ev != '0) begin
         nl.ev     = ev;
         nl.ev_tog = !l.ev_tog;
      end
   end

   // Link-side register
   always_ff @(posedge link_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         l <= I2CS_LINK_RST;
      end else begin
         l <= nl;
      end
   end

   // System side: software clears first so that a same-cycle event wins
   always_comb begin
      logic     rel_req;
      i2cs_ev_t e;
      rel_req = clock_release_set_in || (address_write_in && s.ua);
      e       = l.ev;
      ns      = s;
      if (event_clear_in) begin
         ns.event_flag = 1'b0;
      end
      if (buffer_read_in) begin
         ns.buffer_full = 1'b0;
      end
      if (overflow_clear_in) begin
         ns.overflow = 1'b0;
      end
      if (collision_clear_in) begin
         ns.collision = 1'b0;
      end
      if (buffer_write_in) begin
         ns.buffer      = sw_wdata_in;
         ns.tx          = sw_wdata_in;
         ns.buffer_full = 1'b1;
      end
      if (address_write_in) begin
         ns.addr = sw_wdata_in;
         ns.ua   = 1'b0;
      end
      // Either request releases SCL; a combined one toggles only once
      if (clock_release_set_in) begin
         ns.clk_rel = 1'b1;
      end
      if (rel_req) begin
         ns.rel_tog = !s.rel_tog;
      end
      if (ev_pulse) begin
         if (e.start) begin
            ns.start_seen = 1'b1;
            ns.stop_seen  = 1'b0;
            if (start_event_enable_in) begin
               ns.event_flag = 1'b1;
            end
         end
         if (e.stop) begin
            ns.stop_seen  = 1'b1;
            ns.start_seen = 1'b0;
         end
         if (e.load) begin
            ns.rw       = e.rw;
            ns.ack_time = address_hold_enable_in || data_hold_enable_in;
            if (ns.buffer_full) begin
               ns.overflow = 1'b1;
            end
            if (!ns.buffer_full || buffer_overwrite_enable_in) begin
               ns.buffer      = e.data;
               ns.buffer_full = 1'b1;
            end
         end
         if (e.hold) begin
            ns.event_flag = 1'b1;
            ns.clk_rel    = 1'b0;
         end
         if (e.done) begin
            ns.event_flag = 1'b1;
            ns.ack_time   = 1'b0;
         end
         if (e.ua) begin
            ns.ua = 1'b1;
         end
         if (e.cut) begin
            ns.clk_rel = 1'b0;
         end
         if (e.ackrx) begin
            ns.ack_rx = e.ack_bit;
         end
         if (e.coll) begin
            ns.collision = 1'b1;
         end
      end
      // Overflow blocking is precomputed so the link sees one level
      ns.cfg.stretch   = stretch_enable_in;
      ns.cfg.addr_hold = address_hold_enable_in;
      ns.cfg.data_hold = data_hold_enable_in;
      ns.cfg.ack_val   = ack_value_select_in;
      ns.cfg.ovf_block = ns.overflow ||
                         (ns.buffer_full && !buffer_overwrite_enable_in);
      ns.cfg.coll_en   = slave_collision_detect_enable_in;
   end

   // System-side register
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         s <= I2CS_SYS_RST;
      end else begin
         s <= ns;
      end
   end

   // Outputs straight from state flip-flops
   assign scl_out                   = l.pin_lvl;
   assign scl_oe_n_out              = l.scl_oe_n;
   assign sda_out                   = l.pin_lvl;
   assign sda_oe_n_out              = l.sda_oe_n;
   assign serial_event_flag_out     = s.event_flag;
   assign buffer_full_flag_out      = s.buffer_full;
   assign receive_overflow_flag_out = s.overflow;
   assign address_update_flag_out   = s.ua;
   assign ack_time_flag_out         = s.ack_time;
   assign ack_received_flag_out     = s.ack_rx;
   assign read_write_flag_out       = s.rw;
   assign start_seen_out            = s.start_seen;
   assign stop_seen_out             = s.stop_seen;
   assign bus_collision_flag_out    = s.collision;
   assign clock_release_bit_out     = s.clk_rel;
   assign serial_data_buffer_out    = s.buffer;
   assign slave_address_reg_out     = s.addr;

endmodule : i2cs_slave

`default_nettype wire

// [core/i2cs_toggle_sync.sv]
// Toggle-to-pulse crossing for single events
`timescale 1ns/1ps
`default_nettype none

module i2cs_toggle_sync (
   // Clock and reset of the receiving domain
   input  wire logic clk_in,
   input  wire logic arst_n_in,
   // Toggle from the sending domain, one-cycle pulse here
   input  wire logic toggle_in,
   output logic      pulse_out
);

   logic [2:0] stage;

   // Edge is taken between the second and third stage only
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         stage <= 3'h0;
      end else begin
         stage <= {stage[1:0], toggle_in};
      end
   end

   assign pulse_out = stage[2] ^ stage[1];

endmodule : i2cs_toggle_sync

`default_nettype wire

// [shared/i2cs_pkg.sv]
// Shared constants and carrier types of the I2C slave address/rx/tx engine
package i2cs_pkg;

   // Fixed upper five bits of a 10-bit high address byte
   localparam logic [4:0] I2CS_HI_PATTERN = 5'h1E;
   // Positions of the upper address bits and of the R/W bit
   localparam int unsigned I2CS_A9_POS = 2;
   localparam int unsigned I2CS_A8_POS = 1;
   localparam int unsigned I2CS_RW_POS = 0;
   // Bit counts: a received byte ends after eight rising edges, a sent
   // byte after its eighth falling edge
   localparam logic [3:0] I2CS_BYTE_BITS = 4'h8;
   localparam logic [3:0] I2CS_TX_LAST   = 4'h7;
   // Reset values
   localparam logic [7:0] I2CS_ADDR_RST    = 8'h00;
   localparam logic [7:0] I2CS_BUF_RST     = 8'h00;
   localparam logic       I2CS_CLK_REL_RST = 1'b1;

   // Link-side states, Gray coded along the usual path
   typedef enum logic [2:0] {
      L_IDLE  = 3'h0,
      L_RX    = 3'h1,
      L_ACK   = 3'h3,
      L_WAIT  = 3'h2,
      L_TX    = 3'h6,
      L_TXACK = 3'h7
   } i2cs_lstate_t;

   // Meaning of the byte now being received
   typedef enum logic [1:0] {
      K_HI   = 2'h0,
      K_LO   = 2'h1,
      K_DATA = 2'h3
   } i2cs_kind_t;

   // What follows once a stretch is released
   typedef enum logic [1:0] {
      A_ACK  = 2'h0,
      A_RX   = 2'h1,
      A_TX   = 2'h3,
      A_IDLE = 2'h2
   } i2cs_after_t;

   // Event word passed from the link side to the system side
   typedef struct packed {
      logic       start;
      logic       stop;
      logic       load;
      logic       hold;
      logic       done;
      logic       cut;
      logic       ua;
      logic       ackrx;
      logic       ack_bit;
      logic       coll;
      logic       rw;
      logic [7:0] data;
   } i2cs_ev_t;

   // Configuration levels passed from the system side to the link side
   typedef struct packed {
      logic stretch;
      logic addr_hold;
      logic data_hold;
      logic ack_val;
      logic ovf_block;
      logic coll_en;
   } i2cs_cfg_t;

   // All link-side state
   typedef struct packed {
      i2cs_lstate_t state;
      i2cs_kind_t   kind;
      i2cs_after_t  after;
      logic [3:0]   bitcnt;
      logic [7:0]   shreg;
      logic         ack_ok;
      logic         prior_match;
      logic         rd;
      logic         scl_q;
      logic         sda_q;
      logic         scl_oe_n;
      logic         sda_oe_n;
      logic         pin_lvl;
      i2cs_ev_t     ev;
      logic         ev_tog;
   } i2cs_link_t;

   // All system-side state
   typedef struct packed {
      logic       event_flag;
      logic       buffer_full;
      logic       overflow;
      logic       ua;
      logic       ack_time;
      logic       ack_rx;
      logic       rw;
      logic       start_seen;
      logic       stop_seen;
      logic       collision;
      logic       clk_rel;
      logic [7:0] buffer;
      logic [7:0] addr;
      logic [7:0] tx;
      logic       rel_tog;
      i2cs_cfg_t  cfg;
   } i2cs_sys_t;

   localparam i2cs_link_t I2CS_LINK_RST = '{
      state: L_IDLE, kind: K_HI, after: A_IDLE, scl_q: 1'b1, sda_q: 1'b1,
      scl_oe_n: 1'b1, sda_oe_n: 1'b1, default: '0};

   localparam i2cs_sys_t I2CS_SYS_RST = '{
      clk_rel: I2CS_CLK_REL_RST, buffer: I2CS_BUF_RST, addr: I2CS_ADDR_RST,
      default: '0};

endpackage : i2cs_pkg

// [test/i2cs_master_model.sv]
// Behavioural I2C master on open-drain SCL and SDA
`timescale 1ns/1ps
`default_nettype none
module i2cs_master_model (
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      sda_out
);
   localparam int Q = 1000; // Quarter bit, ns; slow so crossings settle
   initial {scl_out, sda_out} = 2'h3;
   // One bit; the high phase waits out a slave stretch, bounded
   task automatic bit_cyc(input logic b, output logic r);
      sda_out = b;
      #Q scl_out = 1'h1;
      for (int i = 0; i < 500 && scl_in !== 1'h1; i++) #Q;
      #Q r = sda_in;
      #Q scl_out = 1'h0;
      #Q;
   endtask : bit_cyc
   // Start or repeated start, entered with SCL low or idle
   task automatic start();
      sda_out = 1'h1;
      #Q scl_out = 1'h1;
      #Q sda_out = 1'h0;
      #Q scl_out = 1'h0;
      #Q;
   endtask : start
   task automatic stop();
      sda_out = 1'h0;
      #Q scl_out = 1'h1;
      #Q sda_out = 1'h1;
      #Q;
   endtask : stop
   // Eight bits MSB first, then the acknowledge bit
   task automatic xfer(input logic [7:0] d, input logic a,
                       output logic [7:0] q, output logic k);
      for (int i = 7; i >= 0; i--) bit_cyc(d[i], q[i]);
      bit_cyc(a, k);
   endtask : xfer
endmodule : i2cs_master_model
`default_nettype wire

// [test/i2cs_properties.sv]
// Checker of the software-side flags of the I2C slave
`timescale 1ns/1ps
`default_nettype none
module i2cs_properties (
   input wire logic       clk_in, arst_n_in, buffer_write_in,
   input wire logic       buffer_read_in, address_write_in, event_clear_in,
   input wire logic       clock_release_set_in, buffer_full_flag_out,
   input wire logic       address_update_flag_out, serial_event_flag_out,
   input wire logic       clock_release_bit_out,
   input wire logic [7:0] sw_wdata_in, slave_address_reg_out,
   input wire logic [7:0] serial_data_buffer_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   // Hardware sets win over clears, so bench strobes only while SCL is held or the bus is idle
   a_addr_load: assert property (address_write_in |=>
      slave_address_reg_out == $past(sw_wdata_in)) else $error("addr load");
   a_update_clear: assert property (address_write_in |=>
      !address_update_flag_out) else $error("update not cleared");
   a_update_stands: assert property (address_update_flag_out
      && !address_write_in |=> address_update_flag_out) else $error("update");
   a_read_clears: assert property (buffer_read_in |=>
      !buffer_full_flag_out) else $error("full not cleared");
   a_buf_write: assert property (buffer_write_in |=> buffer_full_flag_out
      && serial_data_buffer_out == $past(sw_wdata_in)) else $error("tx load");
   a_event_clear: assert property (event_clear_in |=>
      !serial_event_flag_out) else $error("event not cleared");
   a_release_set: assert property (clock_release_set_in |=>
      clock_release_bit_out) else $error("release not set");
   a_release_stands: assert property (!clock_release_bit_out
      && !clock_release_set_in |=> !clock_release_bit_out) else $error("rel");
endmodule : i2cs_properties
bind i2cs_slave i2cs_properties chk_u (.*);
`default_nettype wire

// [test/i2cs_slave_tb_top.sv]
// Self-checking bench of the I2C slave engine
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) checks_done++; if ((a) !== (e)) begin error_cnt++; \
   $display("wrong value at %0t: %h %h", $time, a, e); end
module i2cs_slave_tb_top;
   logic clk_in = 1'h0, link_clk_in = 1'h0, arst_n_in = 1'h0;
   logic stretch_enable_in = 1'h0, address_hold_enable_in = 1'h0;
   logic data_hold_enable_in = 1'h0, ack_value_select_in = 1'h0;
   logic buffer_overwrite_enable_in = 1'h0, start_event_enable_in = 1'h0;
   logic slave_collision_detect_enable_in = 1'h0, collision_clear_in = 1'h0;
   logic [5:0] st = 6'h00;
   logic [7:0] sw_wdata_in = 8'h00, q;
   logic ak;
   int error_cnt = 0, checks_done = 0;
   wire logic overflow_clear_in, buffer_write_in, buffer_read_in;
   wire logic address_write_in, clock_release_set_in, event_clear_in;
   wire logic m_scl, m_sda, scl_out, sda_out, scl_oe_n_out, sda_oe_n_out;
   wire logic serial_event_flag_out, buffer_full_flag_out, start_seen_out;
   wire logic receive_overflow_flag_out, address_update_flag_out;
   wire logic ack_time_flag_out, ack_received_flag_out, read_write_flag_out;
   wire logic stop_seen_out, bus_collision_flag_out, clock_release_bit_out;
   wire logic [7:0] serial_data_buffer_out, slave_address_reg_out;
   // Open-drain wires with pull-ups
   wire logic scl_in = m_scl & (scl_oe_n_out | scl_out);
   wire logic sda_in = m_sda & (sda_oe_n_out | sda_out);
   assign {overflow_clear_in, buffer_write_in, buffer_read_in,
           address_write_in, clock_release_set_in, event_clear_in} = st;
   i2cs_slave dut_u (.*);
   i2cs_master_model m_u (.scl_in(scl_in), .sda_in(sda_in),
                          .scl_out(m_scl), .sda_out(m_sda));
   always #25 clk_in = ~clk_in;
   always #62.5 link_clk_in = ~link_clk_in;
   // One-cycle software strobe, then time for the crossing
   task automatic sw(input logic [5:0] s, input logic [7:0] d);
      @(negedge clk_in);
      st = s;
      sw_wdata_in = d;
      @(negedge clk_in);
      st = 6'h00;
      repeat (20) @(negedge clk_in);
   endtask : sw
   // Full write match: high byte, low byte, high address back
   task automatic t_addr();
      m_u.start();
      m_u.xfer(8'hF2, 1'h1, q, ak);
      `CHK({ak, address_update_flag_out, read_write_flag_out, serial_event_flag_out, start_seen_out, serial_data_buffer_out}, {5'h0B, 8'hF2})
      sw(6'h0D, 8'h5A);
      m_u.xfer(8'h5A, 1'h1, q, ak);
      `CHK({ak, address_update_flag_out, serial_event_flag_out}, 3'h3)
      sw(6'h0D, 8'hF2);
   endtask : t_addr
   task automatic t_write();
      t_addr();
      m_u.xfer(8'hC3, 1'h1, q, ak);
      `CHK({ak, serial_event_flag_out, serial_data_buffer_out}, 10'h1C3)
      m_u.xfer(8'h3C, 1'h1, q, ak);
      `CHK({buffer_full_flag_out, receive_overflow_flag_out}, 2'h3)
      m_u.stop();
      `CHK({stop_seen_out, start_seen_out}, 2'h2)
   endtask : t_write
   // Restart with read after a full match, master ends with NACK
   task automatic t_read();
      sw(6'h29, 8'h00);
      t_addr();
      m_u.start();
      m_u.xfer(8'hF3, 1'h1, q, ak);
      `CHK({ak, read_write_flag_out, clock_release_bit_out}, 3'h2)
      sw(6'h11, 8'hA5);
      sw(6'h02, 8'h00);
      m_u.xfer(8'hFF, 1'h1, q, ak);
      `CHK({q, ack_received_flag_out, serial_event_flag_out}, {8'hA5, 2'h3})
      m_u.stop();
   endtask : t_read
   // Buffer left full: the next address is refused
   task automatic t_nack();
      m_u.start();
      m_u.xfer(8'hF2, 1'h1, q, ak);
      `CHK({ak, bus_collision_flag_out, ack_time_flag_out}, 3'h4)
      m_u.stop();
   endtask : t_nack
   task automatic stop_test();
      if (error_cnt == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : stop_test
   initial begin
      repeat (12) @(negedge clk_in);
      arst_n_in = 1'h1;
      sw(6'h04, 8'hF2);
      start_event_enable_in = 1'h1;
      t_write();
      stretch_enable_in = 1'h1;
      t_read();
      t_nack();
      stop_test();
   end
   // Run needs about 0.36 ms; a hang is cut at 3 ms
   initial begin
      #3000000;
      error_cnt++;
      stop_test();
   end
endmodule : i2cs_slave_tb_top
`default_nettype wire
